/* File: rtl/pms_defines.svh */
// Constants for the power mode state machine
// Summary of operation
// - Bus access only in Watchdog, On, Wait
// - Interrupt low outside Watchdog and On
// - Off waits for valid turn-on, no timer
// - Undervoltage in Off rejects turn-on, coin power
// - Cold Start entry paths, sequential power-up
// - Reset timer in Cold Start, resets low
// - Cold Start ignores keepalive and standby
// - Watchdog timer, resets high, then On
// - Keepalive low in On leaves On
// - Restart bit with cut count not at max picks Cold Start, else Off
// - Shutdown request bit enters User Off Wait
// - Wait timer, then User Off or Memory Hold
// - Leaving Wait clears shutdown request bit
// - Low-power states exit only on turn-on or undervoltage
// - Memory Hold resets low, clocks off except keep
// - Power gates open on app reset fall
// - Turn-on in Memory Hold: Cold, defaults, flag
// - Memory-hold bucks stay on, reload defaults
// - User Off resets and processor clock logic
// - User Off keeps bucks with mode bit set
// - Turn-on in User Off enters Warm Start
// - Warm Start keeps held bucks, reloads defaults
// - Warm Start reset timer, flag, release reset
// - Undervoltage with cut enabled and cut count not at max enters power cut
// - Cut expiry to Off clears expired bit
`ifndef PMS_DEFINES_SVH
`define PMS_DEFINES_SVH
`define PMS_A_CTRL 12'h000
`define PMS_A_BUCK 12'h004
`define PMS_A_CUT 12'h008
`define PMS_A_STAT 12'h00C
`define PMS_A_FLAG 12'h010
`define PMS_C_USEROFF 0
`define PMS_C_WARM_START_ENABLE 1
`define PMS_C_KARST 2
`define PMS_C_POWER_CUT_ENABLE 3
`define PMS_C_DRM 4
`define PMS_C_CPUCLK 5
`define PMS_C_UOCLK 6
`define PMS_C_EXPN 7
`define PMS_B_UO 8
`define PMS_CUT_MAX 8
`define PMS_CUT_CLR 16
`define PMS_F_MEMHOLD 0
`define PMS_F_WARM 1
`define PMS_F_CUT 2
`define PMS_F_KARST 3
`define PMS_RESET_TICKS 16'h0010
`define PMS_WDOG_TICKS 16'h0040
`define PMS_WAIT_TICKS 16'h0020
`define PMS_SLOT_LAST 3'h4
`endif

/* File: rtl/pms_pkg.sv */
// Types for the power mode state machine
package pms_pkg;
  typedef enum logic [3:0] {
    PMS_OFF, PMS_COLD, PMS_WDOG, PMS_ON, PMS_WAIT, PMS_MEMHOLD, PMS_USEROFF, PMS_WARM, PMS_CUT
  } pms_state_t;

  typedef struct packed {
    pms_state_t st;
    logic [15:0] tmr;
    logic [2:0] slot;
    logic [7:0] ctrl;
    logic [3:0] buck_mh;
    logic [3:0] buck_uo;
    logic [3:0] keep;
    logic [7:0] cut_len;
    logic [3:0] max_cnt;
    logic [3:0] cut_cnt;
    logic [3:0] flags;
    logic [31:0] prdata;
    logic pslverr;
    logic app_rel;
    logic cpu_rel;
    logic gates_closed;
    logic clk_p;
    logic clk_c;
    logic [3:0] bucks;
    logic ldo;
    logic dflt_load;
    logic [1:0] dflt_sel;
    logic core_coin;
    logic slow_prev;
    logic irq;
  } pms_regs_t;
endpackage : pms_pkg

/* File: rtl/pms_top.sv */
// Power mode state machine with APB control registers
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pms_defines.svh"
module pms_top (
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic PREADY_OUT,
  output logic [31:0] PRDATA_OUT,
  output logic PSLVERR_OUT,
  input wire logic SLOW_CLK_IN,
  input wire logic TURN_ON_IN,
  input wire logic SUPPLY_UV_IN,
  input wire logic SUPPLY_ABOVE_ON_IN,
  input wire logic COIN_CELL_OK_IN,
  input wire logic KEEPALIVE_IN,
  input wire logic [1:0] STANDBY_REQUEST_PINS_IN,
  input wire logic [1:0] POWERUP_SELECT_PINS_IN,
  output logic APP_RESET_N_OUT,
  output logic APP_RESET_N_OE_N_OUT,
  output logic CPU_RESET_N_OUT,
  output logic CPU_RESET_N_OE_N_OUT,
  output logic PERIPH_SLOW_CLOCK_OUT,
  output logic CPU_SLOW_CLOCK_OUT,
  output logic [3:0] BUCK_ENABLE_OUT,
  output logic LDO_ENABLE_OUT,
  output logic CORE_POWER_GATE_OUT,
  output logic MEMORY_POWER_GATE_OUT,
  output logic CORE_FROM_COIN_OUT,
  output logic DEFAULTS_LOAD_OUT,
  output logic [1:0] DEFAULTS_SELECT_OUT,
  output logic IRQ_OUT
);
  pms_pkg::pms_regs_t r;
  pms_pkg::pms_regs_t n;

  logic tick;
  logic bus_ok;
  logic setup;
  logic wr;
  logic expired;
  logic cut_allowed;
  pms_pkg::pms_state_t go;

  function automatic logic is_powered(input pms_pkg::pms_state_t s);
    is_powered = (s == pms_pkg::PMS_WDOG) || (s == pms_pkg::PMS_ON) || (s == pms_pkg::PMS_WAIT);
  endfunction : is_powered

  function automatic logic [15:0] timer_len(input pms_pkg::pms_state_t s);
    unique case (s)
      pms_pkg::PMS_COLD, pms_pkg::PMS_WARM: timer_len = `PMS_RESET_TICKS;
      pms_pkg::PMS_WDOG: timer_len = `PMS_WDOG_TICKS;
      pms_pkg::PMS_WAIT: timer_len = `PMS_WAIT_TICKS;
      default: timer_len = 16'h0000;
    endcase
  endfunction : timer_len

  assign tick = SLOW_CLK_IN & ~r.slow_prev;
  assign bus_ok = is_powered(r.st);
  assign setup = PSEL_IN & ~PENABLE_IN;
  assign wr = PSEL_IN & PENABLE_IN & PWRITE_IN & bus_ok;
  assign expired = tick && (r.tmr == 16'h0000);
  assign cut_allowed = r.ctrl[`PMS_C_POWER_CUT_ENABLE] && (r.cut_cnt != r.max_cnt);

  always_comb begin
    n = r;
    go = r.st;
    n.slow_prev = SLOW_CLK_IN;
    n.dflt_load = 1'b0;
    if (tick && (r.tmr != 16'h0000)) begin
      n.tmr = r.tmr - 16'h0001;
    end

    unique case (r.st)
      pms_pkg::PMS_OFF: begin
        // Undervoltage blocks every turn-on attempt
        if (TURN_ON_IN && !SUPPLY_UV_IN) begin
          go = pms_pkg::PMS_COLD;
          n.keep = 4'h0;
        end
      end
      pms_pkg::PMS_COLD, pms_pkg::PMS_WARM: begin
        // Keepalive and standby pins are not looked at here
        if (expired) begin
          go = pms_pkg::PMS_WDOG;
        end
      end
      pms_pkg::PMS_WDOG: begin
        if (expired) begin
          go = pms_pkg::PMS_ON;
        end
      end
      pms_pkg::PMS_ON: begin
        if (r.ctrl[`PMS_C_USEROFF]) begin
          go = pms_pkg::PMS_WAIT;
        end else if (!KEEPALIVE_IN) begin
          // Silent restart shares the cut counter so loops stay bounded
          if (r.ctrl[`PMS_C_KARST] && (r.cut_cnt != r.max_cnt)) begin
            go = pms_pkg::PMS_COLD;
            n.keep = 4'h0;
            n.cut_cnt = r.cut_cnt + 4'h1;
          end else begin
            go = pms_pkg::PMS_OFF;
          end
        end
      end
      pms_pkg::PMS_WAIT: begin
        if (expired) begin
          go = r.ctrl[`PMS_C_WARM_START_ENABLE] ? pms_pkg::PMS_USEROFF : pms_pkg::PMS_MEMHOLD;
        end
      end
      pms_pkg::PMS_MEMHOLD: begin
        if (TURN_ON_IN) begin
          go = pms_pkg::PMS_COLD;
          n.keep = r.buck_mh;
        end
      end
      pms_pkg::PMS_USEROFF: begin
        if (TURN_ON_IN) begin
          go = pms_pkg::PMS_WARM;
          n.keep = r.buck_uo;
        end
      end
      pms_pkg::PMS_CUT: begin
        if (SUPPLY_ABOVE_ON_IN) begin
          go = pms_pkg::PMS_COLD;
          n.keep = 4'h0;
        end else if (expired) begin
          go = pms_pkg::PMS_OFF;
          n.ctrl[`PMS_C_EXPN] = 1'b0;
        end
      end
      default: go = pms_pkg::PMS_OFF;
    endcase

    // Supply loss overrides every other move outside Off and power cut
    if ((r.st != pms_pkg::PMS_OFF) && (r.st != pms_pkg::PMS_CUT) && SUPPLY_UV_IN) begin
      if (cut_allowed) begin
        go = pms_pkg::PMS_CUT;
        n.tmr = {8'h00, r.cut_len};
        n.cut_cnt = r.cut_cnt + 4'h1;
      end else begin
        go = pms_pkg::PMS_OFF;
      end
    end

    // Register writes come after the cut counter steps, so a count clear wins, and before the flag sets and the shutdown-bit clear, so those win
    if (wr) begin
      unique case (PADDR_IN)
        `PMS_A_CTRL: n.ctrl = PWDATA_IN[7:0];
        `PMS_A_BUCK: begin
          n.buck_mh = PWDATA_IN[3:0];
          n.buck_uo = PWDATA_IN[`PMS_B_UO +: 4];
        end
        `PMS_A_CUT: begin
          n.cut_len = PWDATA_IN[7:0];
          n.max_cnt = PWDATA_IN[`PMS_CUT_MAX +: 4];
          if (PWDATA_IN[`PMS_CUT_CLR]) begin
            n.cut_cnt = 4'h0;
          end
        end
        `PMS_A_FLAG: n.flags = r.flags & ~PWDATA_IN[3:0];
        default: n.flags = n.flags;
      endcase
    end

    n.st = go;
    if (go != r.st) begin
      if (go != pms_pkg::PMS_CUT) begin
        n.tmr = timer_len(go);
      end
      if ((go == pms_pkg::PMS_COLD) || (go == pms_pkg::PMS_WARM)) begin
        n.slot = 3'h0;
        n.dflt_load = 1'b1;
        n.dflt_sel = POWERUP_SELECT_PINS_IN;
      end
      if (r.st == pms_pkg::PMS_WAIT) begin
        n.ctrl[`PMS_C_USEROFF] = 1'b0;
      end
      if (r.st == pms_pkg::PMS_MEMHOLD) begin
        n.flags[`PMS_F_MEMHOLD] = 1'b1;
      end
      if ((r.st == pms_pkg::PMS_WARM) && (go == pms_pkg::PMS_WDOG)) begin
        n.flags[`PMS_F_WARM] = 1'b1;
      end
      if (go == pms_pkg::PMS_CUT) begin
        n.flags[`PMS_F_CUT] = 1'b1;
      end
      if ((r.st == pms_pkg::PMS_ON) && (go == pms_pkg::PMS_COLD)) begin
        n.flags[`PMS_F_KARST] = 1'b1;
      end
    end
    // Cut flag is dropped by passing through Off
    if ((go == pms_pkg::PMS_OFF) && (r.st != pms_pkg::PMS_CUT) && (r.st != pms_pkg::PMS_OFF)) begin
      n.flags[`PMS_F_CUT] = n.flags[`PMS_F_CUT];
    end else if (r.st == pms_pkg::PMS_OFF) begin
      n.flags[`PMS_F_CUT] = 1'b0;
    end

    // Power-up sequencing steps one buck per slow tick
    if (((r.st == pms_pkg::PMS_COLD) || (r.st == pms_pkg::PMS_WARM)) && tick && (r.slot != `PMS_SLOT_LAST)) begin
      n.slot = r.slot + 3'h1;
    end

    // Outputs as a function of the state being entered
    n.app_rel = 1'b0;
    n.cpu_rel = 1'b0;
    n.clk_p = 1'b0;
    n.ldo = 1'b0;
    n.bucks = 4'h0;
    n.clk_c = SLOW_CLK_IN & r.ctrl[`PMS_C_DRM];
    n.core_coin = 1'b0;
    unique case (go)
      pms_pkg::PMS_OFF: n.core_coin = SUPPLY_UV_IN & COIN_CELL_OK_IN;
      pms_pkg::PMS_COLD, pms_pkg::PMS_WARM: begin
        // Application reset low in both; processor reset stays high in Warm Start
        n.cpu_rel = (go == pms_pkg::PMS_WARM);
        // Next slot and keep set, so a stale slot cannot switch all bucks on at entry
        for (int i = 0; i < 4; i++) begin
          n.bucks[i] = n.keep[i] | (n.slot > 3'(i));
        end
        n.ldo = (n.slot == `PMS_SLOT_LAST);
        n.clk_p = SLOW_CLK_IN;
        n.clk_c = SLOW_CLK_IN & (r.ctrl[`PMS_C_CPUCLK] | r.ctrl[`PMS_C_DRM]);
      end
      pms_pkg::PMS_WDOG, pms_pkg::PMS_ON, pms_pkg::PMS_WAIT: begin
        n.app_rel = 1'b1;
        n.cpu_rel = 1'b1;
        n.bucks = 4'hF;
        n.ldo = 1'b1;
        n.clk_p = SLOW_CLK_IN;
        n.clk_c = SLOW_CLK_IN & (r.ctrl[`PMS_C_CPUCLK] | r.ctrl[`PMS_C_DRM]);
      end
      pms_pkg::PMS_MEMHOLD: n.bucks = r.buck_mh;
      pms_pkg::PMS_USEROFF: begin
        n.cpu_rel = 1'b1;
        n.bucks = r.buck_uo;
        n.clk_c = SLOW_CLK_IN & ((r.ctrl[`PMS_C_CPUCLK] & r.ctrl[`PMS_C_UOCLK]) | r.ctrl[`PMS_C_DRM]);
      end
      pms_pkg::PMS_CUT: n.bucks = 4'h0;
      default: n.bucks = 4'h0;
    endcase

    // Gates open on the falling app reset into a low-power off state
    if (r.app_rel && !n.app_rel && ((go == pms_pkg::PMS_MEMHOLD) || (go == pms_pkg::PMS_USEROFF))) begin
      n.gates_closed = 1'b0;
    end else if (n.app_rel) begin
      n.gates_closed = 1'b1;
    end else if (!n.bucks[3]) begin
      n.gates_closed = 1'b0;
    end

    n.irq = (|n.flags) && ((go == pms_pkg::PMS_WDOG) || (go == pms_pkg::PMS_ON));

    // Read data is captured in the setup phase and held into the access phase
    if (setup) begin
      n.prdata = 32'h0000_0000;
      n.pslverr = ~bus_ok;
      if (bus_ok && !PWRITE_IN) begin
        unique case (PADDR_IN)
          `PMS_A_CTRL: n.prdata = {24'h00_0000, r.ctrl};
          `PMS_A_BUCK: n.prdata = {20'h0_0000, r.buck_uo, 4'h0, r.buck_mh};
          `PMS_A_CUT: n.prdata = {20'h0_0000, r.max_cnt, r.cut_len};
          `PMS_A_STAT: n.prdata = {16'h0000, STANDBY_REQUEST_PINS_IN, KEEPALIVE_IN, 1'b0, r.cut_cnt, 4'h0, r.st};
          `PMS_A_FLAG: n.prdata = {28'h000_0000, r.flags};
          default: n.pslverr = 1'b1;
        endcase
      end else if (bus_ok) begin
        unique case (PADDR_IN)
          `PMS_A_CTRL, `PMS_A_BUCK, `PMS_A_CUT, `PMS_A_FLAG: n.pslverr = 1'b0;
          default: n.pslverr = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      r <= '0;
      r.ctrl[`PMS_C_CPUCLK] <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign PREADY_OUT = 1'b1;
  assign PRDATA_OUT = r.prdata;
  assign PSLVERR_OUT = r.pslverr & PSEL_IN & PENABLE_IN;
  assign APP_RESET_N_OUT = 1'b0;
  assign APP_RESET_N_OE_N_OUT = r.app_rel;
  assign CPU_RESET_N_OUT = 1'b0;
  assign CPU_RESET_N_OE_N_OUT = r.cpu_rel;
  assign PERIPH_SLOW_CLOCK_OUT = r.clk_p;
  assign CPU_SLOW_CLOCK_OUT = r.clk_c;
  assign BUCK_ENABLE_OUT = r.bucks;
  assign LDO_ENABLE_OUT = r.ldo;
  assign CORE_POWER_GATE_OUT = r.gates_closed;
  assign MEMORY_POWER_GATE_OUT = r.gates_closed;
  assign CORE_FROM_COIN_OUT = r.core_coin;
  assign DEFAULTS_LOAD_OUT = r.dflt_load;
  assign DEFAULTS_SELECT_OUT = r.dflt_sel;
  assign IRQ_OUT = r.irq;
endmodule : pms_top
`default_nettype wire

/* File: verification/pms_host_model.sv */
// Host side: keepalive driver and pulled-up reset lines
`timescale 1ns/1ps
`default_nettype none
module pms_host_model (
  input wire logic alive_in,
  input wire logic app_oe_n_in,
  input wire logic app_d_in,
  input wire logic cpu_oe_n_in,
  input wire logic cpu_d_in,
  output logic keepalive_out,
  output logic app_rst_n_out,
  output logic cpu_rst_n_out
);
  assign keepalive_out = alive_in;
  // Released lines float up to the pull-up level
  assign app_rst_n_out = app_oe_n_in ? 1'b1 : app_d_in;
  assign cpu_rst_n_out = cpu_oe_n_in ? 1'b1 : cpu_d_in;
endmodule : pms_host_model
`default_nettype wire

/* File: verification/pms_monitor.sv */
// Port-level assertions for the power mode state machine
`timescale 1ns/1ps
`default_nettype none
module pms_monitor (
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PSLVERR_OUT,
  input wire logic TURN_ON_IN,
  input wire logic SUPPLY_UV_IN,
  input wire logic APP_RESET_N_OE_N_OUT,
  input wire logic CPU_RESET_N_OE_N_OUT,
  input wire logic PERIPH_SLOW_CLOCK_OUT,
  input wire logic [3:0] BUCK_ENABLE_OUT,
  input wire logic LDO_ENABLE_OUT,
  input wire logic CORE_POWER_GATE_OUT,
  input wire logic MEMORY_POWER_GATE_OUT,
  input wire logic CORE_FROM_COIN_OUT,
  input wire logic DEFAULTS_LOAD_OUT,
  input wire logic IRQ_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);
  // Three cycles of margin hide the one-cycle skew between registered outputs
  property p_bus_refused;
    (!APP_RESET_N_OE_N_OUT) [*3] ##0 (PSEL_IN && PENABLE_IN) |-> PSLVERR_OUT;
  endproperty
  a_bus_refused: assert property (p_bus_refused) else $error("access not refused");
  property p_irq_low;
    (!APP_RESET_N_OE_N_OUT) [*3] |-> !IRQ_OUT;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq high in reset state");
  property p_off_quiet;
    CORE_FROM_COIN_OUT && $past(CORE_FROM_COIN_OUT) |-> BUCK_ENABLE_OUT == 4'h0 && !LDO_ENABLE_OUT && !PERIPH_SLOW_CLOCK_OUT;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("supplies on in off");
  property p_uv_reject;
    CORE_FROM_COIN_OUT && SUPPLY_UV_IN && TURN_ON_IN |=> !DEFAULTS_LOAD_OUT;
  endproperty
  a_uv_reject: assert property (p_uv_reject) else $error("turn-on taken under undervoltage");
  property p_cpu_rise;
    $rose(CPU_RESET_N_OE_N_OUT) |-> $rose(APP_RESET_N_OE_N_OUT);
  endproperty
  a_cpu_rise: assert property (p_cpu_rise) else $error("cpu reset released alone");
  property p_start_hold;
    DEFAULTS_LOAD_OUT |=> (!DEFAULTS_LOAD_OUT && !APP_RESET_N_OE_N_OUT) ##1 (!APP_RESET_N_OE_N_OUT) [*7];
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start reset hold broken");
  property p_gates_open;
    (!APP_RESET_N_OE_N_OUT) [*3] |-> !CORE_POWER_GATE_OUT && !MEMORY_POWER_GATE_OUT;
  endproperty
  a_gates_open: assert property (p_gates_open) else $error("gate closed in reset");
  property p_cpu_follows;
    APP_RESET_N_OE_N_OUT |-> CPU_RESET_N_OE_N_OUT;
  endproperty
  a_cpu_follows: assert property (p_cpu_follows) else $error("cpu reset low with app high");
  property p_seq_start;
    DEFAULTS_LOAD_OUT |-> !LDO_ENABLE_OUT;
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("regulators on at start of sequence");
endmodule : pms_monitor
bind pms_top pms_monitor u_mon (.CLK_SYS_IN, .RSTN_IN, .PSEL_IN, .PENABLE_IN, .PSLVERR_OUT, .TURN_ON_IN,
  .SUPPLY_UV_IN, .APP_RESET_N_OE_N_OUT, .CPU_RESET_N_OE_N_OUT, .PERIPH_SLOW_CLOCK_OUT, .BUCK_ENABLE_OUT,
  .LDO_ENABLE_OUT, .CORE_POWER_GATE_OUT, .MEMORY_POWER_GATE_OUT, .CORE_FROM_COIN_OUT, .DEFAULTS_LOAD_OUT, .IRQ_OUT);
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the power mode state machine
`timescale 1ns/1ps
`default_nettype none
`include "pms_defines.svh"
module tb_top;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ton = 1'b0, uv = 1'b0, alive = 1'b0;
  logic above = 1'b0;
  logic [1:0] div = 2'h0;
  logic [1:0] dsel;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, perr, err, ka, app_oe, cpu_oe, app_d, cpu_d, app_l, cpu_l, pclk, cclk, irq, coin, gate;
  logic [3:0] bucks;
  int bad_count = 0, n_compared = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Slow tick every four cycles keeps the long timers short
  always @(posedge clk) div <= div + 2'h1;
  pms_top dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(perr),
    .SLOW_CLK_IN(div[1]), .TURN_ON_IN(ton), .SUPPLY_UV_IN(uv), .SUPPLY_ABOVE_ON_IN(above), .COIN_CELL_OK_IN(1'b1),
    .KEEPALIVE_IN(ka), .STANDBY_REQUEST_PINS_IN(2'h2), .POWERUP_SELECT_PINS_IN(2'h1), .APP_RESET_N_OUT(app_d),
    .APP_RESET_N_OE_N_OUT(app_oe), .CPU_RESET_N_OUT(cpu_d), .CPU_RESET_N_OE_N_OUT(cpu_oe),
    .PERIPH_SLOW_CLOCK_OUT(pclk), .CPU_SLOW_CLOCK_OUT(cclk), .BUCK_ENABLE_OUT(bucks), .LDO_ENABLE_OUT(),
    .CORE_POWER_GATE_OUT(gate), .MEMORY_POWER_GATE_OUT(), .CORE_FROM_COIN_OUT(coin), .DEFAULTS_LOAD_OUT(),
    .DEFAULTS_SELECT_OUT(dsel), .IRQ_OUT(irq));
  pms_host_model host (.alive_in(alive), .app_oe_n_in(app_oe), .app_d_in(app_d), .cpu_oe_n_in(cpu_oe),
    .cpu_d_in(cpu_d), .keepalive_out(ka), .app_rst_n_out(app_l), .cpu_rst_n_out(cpu_l));
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic bail();
    bad_count++;
    $display("MISMATCH t=%0t wait ran out", $time);
    end_of_test();
  endtask : bail
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
    if (n >= 20) bail();
  endtask : apb
  task automatic rdm(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & mask, exp);
  endtask : rdm
  task automatic wait_app(input logic lvl);
    int n;
    for (n = 0; n < 3000 && app_l !== lvl; n++) @(posedge clk);
    if (n >= 3000) bail();
  endtask : wait_app
  task automatic wait_stat(input logic [3:0] code);
    int n;
    for (n = 0; n < 200; n++) begin
      apb(1'b0, `PMS_A_STAT, 32'h0);
      if (rd[3:0] === code) break;
    end
    if (n >= 200) bail();
  endtask : wait_stat
  task automatic clocks(input logic [1:0] exp);
    logic [1:0] s;
    s = 2'h0;
    repeat (8) begin
      @(posedge clk);
      s = s | {pclk, cclk};
    end
    chk(32'(s), 32'(exp));
  endtask : clocks
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    uv <= 1'b1;
    ton <= 1'b1;
    repeat (20) @(posedge clk);
    chk(32'(coin), 32'h1);
    chk(32'(app_l), 32'h0);
    apb(1'b0, `PMS_A_STAT, 32'h0);
    chk(32'(err), 32'h1);
    uv <= 1'b0;
    repeat (4) @(posedge clk);
    ton <= 1'b0;
    chk(32'(cpu_l), 32'h0);
    wait_app(1'b1);
    chk(32'(cpu_l), 32'h1);
    chk(32'(dsel), 32'h1);
    alive <= 1'b1;
    rdm(`PMS_A_STAT, 32'hF, 32'h2);
    wait_stat(4'h3);
    chk(32'(gate), 32'h1);
    apb(1'b1, `PMS_A_CUT, 32'h0000_0200);
    apb(1'b1, `PMS_A_CTRL, 32'h0000_0024);
    alive <= 1'b0;
    wait_app(1'b0);
    wait_app(1'b1);
    alive <= 1'b1;
    rdm(`PMS_A_FLAG, 32'h8, 32'h8);
    rdm(`PMS_A_STAT, 32'hF00, 32'h100);
    chk(32'(irq), 32'h1);
    apb(1'b1, `PMS_A_FLAG, 32'h0000_000F);
    wait_stat(4'h3);
    apb(1'b1, `PMS_A_BUCK, 32'h0000_0908);
    apb(1'b1, `PMS_A_CTRL, 32'h0000_0063);
    rdm(`PMS_A_STAT, 32'hF, 32'h4);
    alive <= 1'b0;
    wait_app(1'b0);
    repeat (4) @(posedge clk);
    chk(32'(cpu_l), 32'h1);
    chk(32'(bucks), 32'h9);
    chk(32'(gate), 32'h0);
    clocks(2'h1);
    ton <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'({app_l, cpu_l}), 32'h1);
    wait_app(1'b1);
    ton <= 1'b0;
    alive <= 1'b1;
    rdm(`PMS_A_FLAG, 32'h2, 32'h2);
    rdm(`PMS_A_CTRL, 32'h1, 32'h0);
    apb(1'b1, `PMS_A_FLAG, 32'h0000_000F);
    wait_stat(4'h3);
    apb(1'b1, `PMS_A_CTRL, 32'h0000_0021);
    wait_app(1'b0);
    repeat (4) @(posedge clk);
    chk(32'(cpu_l), 32'h0);
    chk(32'(bucks), 32'h8);
    clocks(2'h0);
    ton <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(bucks[3]), 32'h1);
    wait_app(1'b1);
    ton <= 1'b0;
    rdm(`PMS_A_FLAG, 32'h1, 32'h1);
    apb(1'b1, `PMS_A_FLAG, 32'h0000_000F);
    wait_stat(4'h3);
    apb(1'b1, `PMS_A_CTRL, 32'h0000_0030);
    alive <= 1'b0;
    wait_app(1'b0);
    repeat (40) @(posedge clk);
    chk(32'({app_l, irq}), 32'h0);
    clocks(2'h1);
    apb(1'b0, `PMS_A_STAT, 32'h0);
    chk(32'(err), 32'h1);
    // Successful cut first, then one left to expire into Off
    ton <= 1'b1;
    alive <= 1'b1;
    wait_app(1'b1);
    ton <= 1'b0;
    apb(1'b1, `PMS_A_CUT, 32'h0001_0210);
    apb(1'b1, `PMS_A_CTRL, 32'h0000_00A8);
    uv <= 1'b1;
    wait_app(1'b0);
    uv <= 1'b0;
    above <= 1'b1;
    wait_app(1'b1);
    above <= 1'b0;
    rdm(`PMS_A_FLAG, 32'h4, 32'h4);
    rdm(`PMS_A_CTRL, 32'h80, 32'h80);
    rdm(`PMS_A_STAT, 32'hF00, 32'h100);
    uv <= 1'b1;
    repeat (120) @(posedge clk);
    chk(32'(coin), 32'h1);
    uv <= 1'b0;
    ton <= 1'b1;
    wait_app(1'b1);
    ton <= 1'b0;
    rdm(`PMS_A_CTRL, 32'h80, 32'h0);
    rdm(`PMS_A_FLAG, 32'h4, 32'h0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
